// *** hdl/i2c_ctrl_regs.vh ***
// Constants of the two-wire bus control block: offsets, fields, reset values, timing.
`ifndef I2C_CTRL_REGS_VH
`define I2C_CTRL_REGS_VH

// ----------------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------------
`define OFS_CONTROL      4'h0
`define OFS_STATUS       4'h4
`define OFS_DATA         4'h8
`define OFS_DIVIDER      4'hc

// ----------------------------------------------------------------------------
// Control register fields.
// ----------------------------------------------------------------------------
`define CTL_ENABLE       7
`define CTL_IRQ_EN       6
`define CTL_MASTER       5
`define CTL_TRANSMIT     4
`define CTL_ACK_SUPP     3
`define CTL_RSTART       2
`define CTL_RESET        8'h00

// ----------------------------------------------------------------------------
// Status register fields.
// ----------------------------------------------------------------------------
`define STS_BUSY         0
`define STS_ARB_LOST     1
`define STS_RX_VALID     2
`define STS_TX_READY     3
`define STS_NACKED       4
`define STS_DONE         5

// ----------------------------------------------------------------------------
// Timing: quarter bit period minus one, in system clock cycles.
// ----------------------------------------------------------------------------
`define DIV_RESET        16'h0032

`endif

// *** hdl/i2c_ctrl.v ***
// Two-wire bus master controller with an AHB-Lite control register file.
`timescale 1ns/1ps
`include "i2c_ctrl_regs.vh"

// Overview of operation
// - Enable bit 7 gates the whole engine.
// - Interrupt only raised when bit 6 set.
// - Master bit rising issues start, master mode.
// - Master bit falling issues stop, slave mode.
// - Direction bit 4: 0 receive, 1 transmit.
// - Receiver acks unless bit 3 is set.
// - Repeat start bit generates restart when master.
// - Repeat start bit always reads zero.
// - Misplaced repeat start counts as arbitration loss.
module i2c_ctrl
#(
  parameter DIV_W = 16                         // Width of the quarter-bit divider.
)
(
  input  wire        clk_sys,                  // System clock, 200 MHz.
  input  wire        srst,                     // Synchronous reset, active high.
  input  wire        hsel,                     // AHB-Lite slave select.
  input  wire [31:0] haddr,                    // AHB-Lite address.
  input  wire [1:0]  htrans,                   // AHB-Lite transfer type.
  input  wire        hwrite,                   // AHB-Lite write flag.
  input  wire [2:0]  hsize,                    // AHB-Lite transfer size.
  input  wire [31:0] hwdata,                   // AHB-Lite write data.
  input  wire        hready,                   // AHB-Lite bus ready in.
  output reg  [31:0] hrdata,                   // AHB-Lite read data.
  output reg         hreadyout,                // AHB-Lite ready out.
  output reg         hresp,                    // AHB-Lite response, always OKAY.
  input  wire        scl_i,                    // Clock line level.
  output reg         scl_o,                    // Clock line output value, always low.
  output reg         scl_oe,                   // Clock line pull-down enable.
  input  wire        sda_i,                    // Data line level.
  output reg         sda_o,                    // Data line output value, always low.
  output reg         sda_oe,                   // Data line pull-down enable.
  output reg         irq                       // Interrupt request, active high.
);

  // --------------------------------------------------------------------------
  // Engine states.
  // --------------------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'd0;            // Bus released.
  localparam [2:0] ST_START = 3'd1;            // Start or repeated start.
  localparam [2:0] ST_BIT   = 3'd2;            // Eight data bits.
  localparam [2:0] ST_ACK   = 3'd3;            // Acknowledge bit.
  localparam [2:0] ST_HOLD  = 3'd4;            // Clock held low between bytes.
  localparam [2:0] ST_STOP  = 3'd5;            // Stop condition.

  // --------------------------------------------------------------------------
  // Pin synchronisers.
  // --------------------------------------------------------------------------
  reg [1:0] scl_sync_reg;                      // Clock line, two stages.
  reg [1:0] sda_sync_reg;                      // Data line, two stages.

  // Both bus lines pass two flops before use.
  always @(posedge clk_sys)
  begin
    scl_sync_reg <= {scl_sync_reg[0], scl_i};
    sda_sync_reg <= {sda_sync_reg[0], sda_i};
  end

  wire scl_in = scl_sync_reg[1];               // Synchronised clock line.
  wire sda_in = sda_sync_reg[1];               // Synchronised data line.

  // --------------------------------------------------------------------------
  // Registers and engine state.
  // --------------------------------------------------------------------------
  reg [7:0]       bus_control_reg;             // Control register, restart bit unstored.
  reg [DIV_W-1:0] div_reg;                     // Quarter-bit divider reload.
  reg [DIV_W-1:0] tick_cnt_reg;                // Divider counter.
  reg             tick_reg;                    // One-cycle quarter-bit enable.
  reg [2:0]       state_reg;                   // Engine state.
  reg [1:0]       phase_reg;                   // Quarter within a bit.
  reg [2:0]       bit_cnt_reg;                 // Bit index within a byte.
  reg [7:0]       shift_reg;                   // Data shift register.
  reg             start_req_reg;               // Pending start from master rise.
  reg             stop_req_reg;                // Pending stop from master fall.
  reg             rstart_req_reg;              // Pending repeated start.
  reg             arb_lost_reg;                // Arbitration lost flag.
  reg             nacked_reg;                  // Last transmit byte was not acked.
  reg             done_reg;                    // Byte transfer complete flag.
  reg [1:0]       tx_cnt_reg;                  // Two-entry transmit buffer count.
  reg [7:0]       tx_buf_reg [0:1];            // Transmit buffer storage.
  reg             tx_rd_reg;                   // Transmit buffer read slot.
  reg             tx_wr_reg;                   // Transmit buffer write slot.
  reg [1:0]       rx_cnt_reg;                  // Two-entry receive buffer count.
  reg [7:0]       rx_buf_reg [0:1];            // Receive buffer storage.
  reg             rx_rd_reg;                   // Receive buffer read slot.
  reg             rx_wr_reg;                   // Receive buffer write slot.

  // AHB address-phase capture.
  reg             dp_wr_reg;                   // Data phase is a write.
  reg             dp_rd_reg;                   // Data phase is a read.
  reg [3:0]       dp_addr_reg;                 // Captured byte offset.

  wire ctl_en  = bus_control_reg[`CTL_ENABLE];   // Engine enable.
  wire ctl_mst = bus_control_reg[`CTL_MASTER];   // Master select.
  wire ctl_tx  = bus_control_reg[`CTL_TRANSMIT]; // Direction.
  wire busy    = (state_reg != ST_IDLE);         // Bus owned by this engine.

  // Returns one when the captured offset matches a register.
  function is_ofs;
    input [3:0] a;
    input [3:0] o;
    begin
      is_ofs = (a == o);
    end
  endfunction

  wire wr_ctl  = dp_wr_reg && is_ofs(dp_addr_reg, `OFS_CONTROL);
  wire wr_data = dp_wr_reg && is_ofs(dp_addr_reg, `OFS_DATA);
  wire rd_data = dp_rd_reg && is_ofs(dp_addr_reg, `OFS_DATA);
  wire wr_div  = dp_wr_reg && is_ofs(dp_addr_reg, `OFS_DIVIDER);

  // Buffer handshakes: the engine is the drain of tx and the source of rx.
  wire tx_push = wr_data && (tx_cnt_reg != 2'd2);     // Write refused when full.
  wire rx_pop  = rd_data && (rx_cnt_reg != 2'd0);     // Read of empty buffer pops nothing.
  wire rx_ready = (rx_cnt_reg != 2'd2);               // Receive side can take a byte.
  wire new_mst = hwdata[`CTL_MASTER];                 // Master bit being written.

  // --------------------------------------------------------------------------
  // AHB-Lite slave: zero wait states, OKAY always.
  // --------------------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      dp_wr_reg   <= 1'b0;
      dp_rd_reg   <= 1'b0;
      dp_addr_reg <= 4'h0;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
    else if (hready)
    begin
      // Only NONSEQ or SEQ transfers open a data phase.
      dp_wr_reg   <= hsel && htrans[1] && hwrite;
      dp_rd_reg   <= hsel && htrans[1] && !hwrite;
      dp_addr_reg <= haddr[3:0];
    end
  end

  // Read data are taken in the address phase into a flop.
  always @(posedge clk_sys)
  begin
    if (srst)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      if (haddr[3:0] == `OFS_CONTROL)
        hrdata <= {24'h00_0000, bus_control_reg & 8'hfb};
      else if (haddr[3:0] == `OFS_STATUS)
        hrdata <= {26'h000_0000, done_reg, nacked_reg, (tx_cnt_reg != 2'd2),
                   (rx_cnt_reg != 2'd0), arb_lost_reg, busy};
      else if (haddr[3:0] == `OFS_DATA)
        hrdata <= {24'h00_0000, rx_buf_reg[rx_rd_reg]};
      else if (haddr[3:0] == `OFS_DIVIDER)
        hrdata <= {{(32-DIV_W){1'b0}}, div_reg};
      else
        hrdata <= 32'h0000_0000;                              // Unmapped reads zero.
    end
  end

  // --------------------------------------------------------------------------
  // Control register and requests.
  // --------------------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      bus_control_reg <= `CTL_RESET;
      div_reg         <= `DIV_RESET;
      start_req_reg   <= 1'b0;
      stop_req_reg    <= 1'b0;
      rstart_req_reg  <= 1'b0;
    end
    else
    begin
      if (wr_div)
        div_reg <= hwdata[DIV_W-1:0];
      if (wr_ctl)
      begin
        // The restart bit is never stored.
        bus_control_reg <= hwdata[7:0] & 8'hfb;
        if (new_mst && !ctl_mst)
          start_req_reg <= 1'b1;
        if (!new_mst && ctl_mst)
          stop_req_reg <= 1'b1;
        if (hwdata[`CTL_RSTART])
          rstart_req_reg <= 1'b1;
      end
      // Requests clear at quarter 3 of idle (start) or hold (stop, restart), when disabled, or on arbitration loss.
      if (!ctl_en || arb_lost_reg)
      begin
        start_req_reg  <= 1'b0;
        stop_req_reg   <= 1'b0;
        rstart_req_reg <= 1'b0;
        if (arb_lost_reg)
          bus_control_reg[`CTL_MASTER] <= 1'b0;
      end
      else if (tick_reg && phase_reg == 2'd3)
      begin
        if (state_reg == ST_IDLE)
          start_req_reg <= 1'b0;
        if (state_reg == ST_HOLD)
        begin
          stop_req_reg   <= 1'b0;
          rstart_req_reg <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Quarter-bit divider producing a one-cycle enable.
  // --------------------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (srst || !ctl_en)
    begin
      tick_cnt_reg <= {DIV_W{1'b0}};
      tick_reg     <= 1'b0;
    end
    else if (tick_cnt_reg >= div_reg)
    begin
      tick_cnt_reg <= {DIV_W{1'b0}};
      tick_reg     <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
      tick_reg     <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Bus engine: each bit has four quarters; the clock line is high in 1, 2 and 3.
  // --------------------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (srst || !ctl_en)
    begin
      state_reg    <= ST_IDLE;
      phase_reg    <= 2'd0;
      bit_cnt_reg  <= 3'd0;
      shift_reg    <= 8'h00;
      scl_oe       <= 1'b0;
      sda_oe       <= 1'b0;
      arb_lost_reg <= 1'b0;
      nacked_reg   <= 1'b0;
      done_reg     <= 1'b0;
      tx_cnt_reg   <= 2'd0;
      tx_rd_reg    <= 1'b0;
      tx_wr_reg    <= 1'b0;
      rx_cnt_reg   <= 2'd0;
      rx_rd_reg    <= 1'b0;
      rx_wr_reg    <= 1'b0;
    end
    else
    begin
      // Software-side buffer traffic.
      if (tx_push)
      begin
        tx_buf_reg[tx_wr_reg] <= hwdata[7:0];
        tx_wr_reg <= !tx_wr_reg;
      end
      if (rx_pop)
        rx_rd_reg <= !rx_rd_reg;
      // Status flags clear on a write of one; a same-cycle set wins below.
      if (dp_wr_reg && is_ofs(dp_addr_reg, `OFS_STATUS))
      begin
        if (hwdata[`STS_ARB_LOST]) arb_lost_reg <= 1'b0;
        if (hwdata[`STS_NACKED])   nacked_reg   <= 1'b0;
        if (hwdata[`STS_DONE])     done_reg     <= 1'b0;
      end
      tx_cnt_reg <= tx_cnt_reg + {1'b0, tx_push};
      rx_cnt_reg <= rx_cnt_reg - {1'b0, rx_pop};
      if (tick_reg)
      begin
        phase_reg <= phase_reg + 2'd1;
        case (state_reg)
          ST_IDLE:
          begin
            phase_reg <= 2'd0;
            if (start_req_reg && phase_reg == 2'd0)
            begin
              state_reg <= ST_START;
              sda_oe    <= 1'b1;                              // Data falls, clock high.
            end
          end
          ST_START:
          begin
            if (phase_reg == 2'd3)
            begin
              scl_oe    <= 1'b1;
              state_reg <= ST_HOLD;
            end
          end
          ST_HOLD:
          begin
            // Clock held low; the next action is picked at quarter 3.
            scl_oe <= 1'b1;
            if (phase_reg == 2'd3)
            begin
              if (stop_req_reg)
              begin
                sda_oe    <= 1'b1;
                state_reg <= ST_STOP;
              end
              else if (rstart_req_reg)
              begin
                sda_oe    <= 1'b0;
                scl_oe    <= 1'b0;
                state_reg <= ST_IDLE;
              end
              else if (ctl_tx && tx_cnt_reg != 2'd0)
              begin
                shift_reg   <= tx_buf_reg[tx_rd_reg];
                tx_rd_reg   <= !tx_rd_reg;
                tx_cnt_reg  <= tx_cnt_reg + {1'b0, tx_push} - 2'd1;
                sda_oe      <= !tx_buf_reg[tx_rd_reg][7];
                bit_cnt_reg <= 3'd7;
                state_reg   <= ST_BIT;
              end
              else if (!ctl_tx && rx_ready)
              begin
                sda_oe      <= 1'b0;
                bit_cnt_reg <= 3'd7;
                state_reg   <= ST_BIT;
              end
            end
          end
          ST_BIT:
          begin
            if (phase_reg == 2'd0)
              scl_oe <= 1'b0;
            else if (phase_reg == 2'd1)
            begin
              // Driving high but reading low means another master won.
              if (ctl_tx && !sda_oe && !sda_in)
                arb_lost_reg <= 1'b1;
              shift_reg <= {shift_reg[6:0], sda_in};
            end
            else if (phase_reg == 2'd3)
            begin
              scl_oe <= 1'b1;
              if (bit_cnt_reg == 3'd0)
              begin
                sda_oe    <= !ctl_tx && !bus_control_reg[`CTL_ACK_SUPP];
                state_reg <= ST_ACK;
              end
              else
              begin
                sda_oe      <= ctl_tx && !shift_reg[7];
                bit_cnt_reg <= bit_cnt_reg - 3'd1;
              end
            end
          end
          ST_ACK:
          begin
            if (phase_reg == 2'd0)
              scl_oe <= 1'b0;
            else if (phase_reg == 2'd1 && ctl_tx)
              nacked_reg <= sda_in;
            else if (phase_reg == 2'd3)
            begin
              scl_oe    <= 1'b1;
              sda_oe    <= 1'b0;
              done_reg  <= 1'b1;
              state_reg <= ST_HOLD;
              if (!ctl_tx)
              begin
                rx_buf_reg[rx_wr_reg] <= shift_reg;
                rx_wr_reg  <= !rx_wr_reg;
                rx_cnt_reg <= rx_cnt_reg + 2'd1 - {1'b0, rx_pop};
              end
            end
          end
          ST_STOP:
          begin
            if (phase_reg == 2'd1)
              scl_oe <= 1'b0;
            else if (phase_reg == 2'd3)
            begin
              sda_oe    <= 1'b0;                              // Data rises, clock high.
              state_reg <= ST_IDLE;
            end
          end
          default:
            state_reg <= ST_IDLE;
        endcase
      end
      // A restart outside master mode or on an idle bus loses arbitration.
      if (rstart_req_reg && (state_reg == ST_IDLE || !ctl_mst))
        arb_lost_reg <= 1'b1;
      if (arb_lost_reg)
      begin
        state_reg <= ST_IDLE;
        scl_oe    <= 1'b0;
        sda_oe    <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Fixed pin levels and interrupt request.
  // --------------------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      irq   <= 1'b0;
    end
    else
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      irq   <= bus_control_reg[`CTL_IRQ_EN] && (done_reg || arb_lost_reg);
    end
  end

endmodule // i2c_ctrl

// *** sim/i2c_ctrl_checker_assertions.sv ***
// Checker of the two-wire control block, bound to its top module.
`timescale 1ns/1ps
module i2c_ctrl_checker
#(
  parameter DIV_W = 16
)
(
  input wire        clk_sys,
  input wire        srst,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [2:0]  hsize,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        scl_i,
  input wire        scl_o,
  input wire        scl_oe,
  input wire        sda_i,
  input wire        sda_o,
  input wire        sda_oe,
  input wire        irq
);
  // ---------------------------------------------------------------------------
  // Shadow of the control register, rebuilt from bus writes.
  // ---------------------------------------------------------------------------
  reg       wr_ph;  // A control write is in its data phase.
  reg [7:0] ctl_q;  // Last value software wrote to control.
  wire      rd_ctl = hsel && hready && htrans[1] && !hwrite && haddr == 32'h0;
  // Track the address phase, then take the data of a control write.
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      wr_ph <= 1'b0;
      ctl_q <= 8'h00;
    end
    else
    begin
      wr_ph <= hsel && hready && htrans[1] && hwrite && haddr == 32'h0;
      if (wr_ph)
        ctl_q <= hwdata[7:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ---------------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------------
  a_reset_quiet: assert property ($fell(srst) |-> !scl_oe && !sda_oe && !irq && hrdata == 32'h0)
    else $error("outputs not idle after reset");
  a_repeat_start_request_reads_zero: assert property (rd_ctl |=> hrdata[2] == 1'b0)
    else $error("repeat start bit read back as one");
  a_ctl_echo: assert property (rd_ctl |=> hrdata[7:6] == $past(ctl_q[7:6]) && hrdata[4:3] == $past(ctl_q[4:3]))
    else $error("control read differs from written value");
  a_off_no_drive: assert property (!ctl_q[7] [*3] |-> !scl_oe && !sda_oe)
    else $error("disabled block drives the lines");
  a_irq_gated: assert property (!ctl_q[6] [*2] |-> !irq)
    else $error("interrupt raised while not enabled");
  a_start_gen: assert property ($rose(ctl_q[5]) && ctl_q[7] |-> ##[1:400] ($rose(sda_oe) && !scl_oe))
    else $error("no start after master select");
  a_stop_gen: assert property ($fell(ctl_q[5]) && ctl_q[7] |-> ##[1:1000] ($fell(sda_oe) && !scl_oe))
    else $error("no stop after leaving master mode");
  a_ack_quiet: assert property ((ctl_q[7] && ctl_q[5] && !ctl_q[4] && ctl_q[3]) [*8] |-> !sda_oe)
    else $error("receiver drives data with acknowledge suppressed");
  a_repeat_start_request_idle_arb: assert property (wr_ph && hwdata[7:5] == 3'b110 && hwdata[2] && !ctl_q[5] |-> ##[1:8] irq)
    else $error("misplaced repeat start not flagged");
  c_start: cover property ($rose(sda_oe) && !scl_oe);
  c_stop: cover property ($fell(sda_oe) && !scl_oe);
  c_irq: cover property ($rose(irq));
endmodule // i2c_ctrl_checker

bind i2c_ctrl i2c_ctrl_checker #(.DIV_W(DIV_W)) u_checker (.*);

// *** sim/bus_target_model.sv ***
// Behavioural target device that answers on the two-wire bus.
`timescale 1ns/1ps
module bus_target_model
(
  input  wire       scl,
  input  wire       sda,
  input  wire [7:0] tx_byte,
  output reg        sda_pull,
  output reg  [7:0] last_rx,
  output reg        master_acked,
  output reg  [7:0] byte_cnt,
  output reg  [7:0] start_cnt,
  output reg  [7:0] stop_cnt
);
  reg [3:0] idx;      // Bits clocked in the current byte.
  reg [7:0] shreg;    // Incoming byte.
  reg       addr_ph;  // The next byte is an address.
  reg       sending;  // This device returns data bytes.
  initial
  begin
    {sda_pull, last_rx, master_acked, byte_cnt, start_cnt, stop_cnt, idx, shreg, addr_ph, sending} = 0;
  end
  // A start reframes the bytes; a stop ends the transfer.
  always @(sda)
  begin
    if (scl === 1'b1)
    begin
      if (sda === 1'b0)
        start_cnt = start_cnt + 8'h01;
      else
        stop_cnt = stop_cnt + 8'h01;
      addr_ph = (sda === 1'b0);
      idx = 4'h0;
      sending = 1'b0;
    end
  end
  // Data are taken on the rising clock, the ninth bit is the acknowledge.
  always @(posedge scl)
  begin
    if (idx < 4'h8)
      shreg = {shreg[6:0], sda};
    else
    begin
      master_acked = ~sda;
      byte_cnt = byte_cnt + 8'h01;
    end
    idx = idx + 4'h1;
  end
  // Drive while the clock is low.
  always @(negedge scl)
  begin
    if (idx == 4'h9)
    begin
      idx = 4'h0;
      sending = addr_ph ? last_rx[0] : (sending && master_acked);
      addr_ph = 1'b0;
    end
    if (idx == 4'h8 && !sending)
      last_rx = shreg;
    if (idx == 4'h8)
      sda_pull = !sending;
    else
      sda_pull = sending && !tx_byte[3'h7 - idx[2:0]];
  end
endmodule // bus_target_model

// *** sim/tb.sv ***
// Self-checking bench of the two-wire control block.
`timescale 1ns/1ps
`include "i2c_ctrl_regs.vh"
module tb;
  // ---------------------------------------------------------------------------
  // Signals, line resolution with pull-ups, and instances.
  // ---------------------------------------------------------------------------
  reg         clk_sys = 1'b0;
  reg         srst    = 1'b1;
  reg         hsel    = 1'b0;
  reg  [31:0] haddr   = 32'h0;
  reg  [1:0]  htrans  = 2'h0;
  reg         hwrite  = 1'b0;
  reg  [31:0] hwdata  = 32'h0;
  reg  [7:0]  tx_byte = 8'h00;
  reg  [31:0] seed    = 32'h005a;
  reg  [31:0] rd;
  reg  [7:0]  v, d1, b0, s0, p0;
  integer     err_count = 0;
  integer     checks = 0;
  integer     cyc = 0;
  integer     i;
  wire [31:0] hrdata;
  wire        hreadyout, scl_oe, sda_oe, irq, sda_pull, master_acked;
  wire [7:0]  last_rx, byte_cnt, start_cnt, stop_cnt;
  wire        scl_line = !(scl_oe === 1'b1);
  wire        sda_line = !(sda_oe === 1'b1 || sda_pull === 1'b1);
  i2c_ctrl dut (.clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .scl_i(scl_line), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda_line), .sda_o(), .sda_oe(sda_oe), .irq(irq));
  bus_target_model target (.scl(scl_line), .sda(sda_line), .tx_byte(tx_byte), .sda_pull(sda_pull),
    .last_rx(last_rx), .master_acked(master_acked), .byte_cnt(byte_cnt), .start_cnt(start_cnt),
    .stop_cnt(stop_cnt));
  // ---------------------------------------------------------------------------
  // Clock, hang guard, helpers.
  // ---------------------------------------------------------------------------
  initial
  begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // A hang counts as a failure.
  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      err_count = err_count + 1;
      conclude;
    end
  end
  function [31:0] rnd(input [31:0] s);
    reg [31:0] x;
  begin
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    rnd = x ^ (x << 5);
  end
  endfunction
  task chk_reg(input [31:0] got, input [31:0] exp);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("unexpected at %0t: register read %h, wanted %h", $time, got, exp);
    end
  end
  endtask
  task chk_bus(input [31:0] got, input [31:0] exp);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("unexpected at %0t: bus side value %h, wanted %h", $time, got, exp);
    end
  end
  endtask
  // One single word transfer; each phase ends at a rising edge that finds ready high.
  task ahb(input w, input [31:0] a, input [31:0] d);
  begin
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1)
      @(posedge clk_sys);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1)
      @(posedge clk_sys);
    rd = hrdata;
  end
  endtask
  // Waits for a byte count, then for the clock low.
  task wait_bytes(input [7:0] n);
  begin
    while (byte_cnt != n)
      @(posedge clk_sys);
    while (scl_line !== 1'b0)
      @(posedge clk_sys);
  end
  endtask
  task conclude;
  begin
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    ahb(0, `OFS_CONTROL, 0);
    chk_reg(rd, {24'h0, `CTL_RESET});
    ahb(0, `OFS_DIVIDER, 0);
    chk_reg(rd, {16'h0, `DIV_RESET});
    ahb(1, `OFS_DIVIDER, 32'h2);
    s0 = start_cnt;
    for (i = 0; i < 4; i = i + 1)
    begin
      seed = rnd(seed);
      v = seed[7:0] & 8'h7f | 8'h04;
      ahb(1, `OFS_CONTROL, {24'h0, v});
      ahb(0, `OFS_CONTROL, 0);
      chk_reg(rd, {24'h0, v & 8'hfb});
    end
    chk_bus(start_cnt, s0);
    ahb(1, `OFS_CONTROL, 0);
    ahb(0, 32'h10, 0);
    chk_reg(rd, 0);
    // Misplaced repeat start, interrupt masked then enabled.
    ahb(1, `OFS_CONTROL, 32'h80);
    ahb(1, `OFS_CONTROL, 32'h84);
    ahb(0, `OFS_STATUS, 0);
    chk_reg({31'h0, rd[`STS_ARB_LOST]}, 1);
    chk_bus({31'h0, irq}, 0);
    ahb(1, `OFS_CONTROL, 32'hc0);
    ahb(0, `OFS_STATUS, 0);
    chk_bus({31'h0, irq}, 1);
    ahb(1, `OFS_STATUS, 32'h2);
    ahb(0, `OFS_STATUS, 0);
    chk_bus({31'h0, irq}, 0);
    ahb(1, `OFS_CONTROL, 32'hc4);
    ahb(0, `OFS_STATUS, 0);
    chk_bus({31'h0, irq}, 1);
    ahb(1, `OFS_STATUS, 32'h2);
    ahb(1, `OFS_CONTROL, 32'h80);
    // Master write of two bytes; a third push is refused.
    seed = rnd(seed);
    d1 = seed[7:0];
    b0 = byte_cnt;
    p0 = stop_cnt;
    s0 = start_cnt;
    ahb(1, `OFS_DATA, 32'ha4);
    ahb(1, `OFS_DATA, {24'h0, d1});
    ahb(1, `OFS_DATA, 32'h5a);
    ahb(1, `OFS_CONTROL, 32'hb0);
    wait_bytes(b0 + 8'h1);
    chk_bus(last_rx, 8'ha4);
    wait_bytes(b0 + 8'h2);
    chk_bus(last_rx, d1);
    ahb(1, `OFS_CONTROL, 32'h90);
    while (stop_cnt != p0 + 8'h1)
      @(posedge clk_sys);
    chk_bus(start_cnt, s0 + 8'h1);
    chk_bus(byte_cnt, b0 + 8'h2);
    // Master read of two bytes: the first acknowledged, the second not.
    seed = rnd(seed);
    tx_byte = seed[7:0];
    b0 = byte_cnt;
    p0 = stop_cnt;
    ahb(1, `OFS_DATA, 32'ha5);
    ahb(1, `OFS_CONTROL, 32'hb0);
    wait_bytes(b0 + 8'h1);
    ahb(1, `OFS_CONTROL, 32'ha0);
    wait_bytes(b0 + 8'h2);
    chk_bus({31'h0, master_acked}, 1);
    ahb(1, `OFS_CONTROL, 32'ha8);
    wait_bytes(b0 + 8'h3);
    chk_bus({31'h0, master_acked}, 0);
    ahb(1, `OFS_CONTROL, 32'h88);
    for (i = 0; i < 2; i = i + 1)
    begin
      ahb(0, `OFS_DATA, 0);
      chk_reg(rd, {24'h0, tx_byte});
    end
    while (stop_cnt != p0 + 8'h1)
      @(posedge clk_sys);
    chk_bus(stop_cnt, p0 + 8'h1);
    conclude;
  end
endmodule // tb
